//--- rtl/igc_map.svh
// Register offsets, field positions, thresholds and timing counts.
// Assumes a 50 MHz system clock and a 100 ms control tick.
//
// Summary of operation
// - Generator enabled while a mode runs starts combined operation.
// - Generator enabled while the unit is off starts standalone operation.
// - Power stop, a second generator press or the off timer end the generator.
// - Generator pauses while the indoor fan stands and resumes when it runs.
// - Out-of-band intake temperature pauses it until six in-band minutes pass.
// - Combined operation powers the generator only at or above 430 rpm.
// - Standalone: user fan speed, auto means cooling medium, boost and quiet off.
// - Combined operation takes fan speed and airflow from the running mode.
// - Standalone operation drives the vane from the user swing setting.
// - On timer while stopped restores previous operation and generator status.
// - Off timer stops everything and saves the generator on/off status.
// - After power failure the previous standalone or combined operation resumes.
// - Check mode declares the fault code on disconnection and blinks timer LED.
// - Disconnection: abnormal 5.9 s inside the 6 s window from 1 s.
// - Each disconnection counts up and removes generator power for five minutes.
// - Check mode at one disconnection stores the code, blinks, generator LED off.
// - Normal mode at three disconnections stores the code, LED off, no blink.
// - Outside check mode the disconnection counter clears when operation stops.
// - Discharge fault: after thirty powered minutes, abnormal for five seconds.
// - Each discharge fault counts and powers off 30 minutes; twelve logs hidden.
// - Discharge counter clears after fifty normal minutes or on stop.
`ifndef IGC_MAP_SVH
`define IGC_MAP_SVH

`define IGC_CLK_NS        20
`define IGC_TICK_NS       100000000
`define IGC_TICK_CYCLES   (`IGC_TICK_NS / `IGC_CLK_NS)
`define IGC_TICKS_PER_S   10
`define IGC_TICKS_PER_MIN 600

`define IGC_DISC_START  16'd10
`define IGC_DISC_END    16'd70
`define IGC_DISC_ABN    16'd59
`define IGC_DISC_OFF    16'(5 * `IGC_TICKS_PER_MIN)
`define IGC_DSCH_START  16'(30 * `IGC_TICKS_PER_MIN)
`define IGC_DSCH_ABN    16'(5 * `IGC_TICKS_PER_S)
`define IGC_DSCH_OFF    16'(30 * `IGC_TICKS_PER_MIN)
`define IGC_DSCH_CLR    16'(50 * `IGC_TICKS_PER_MIN)
`define IGC_TEMP_OK     16'(6 * `IGC_TICKS_PER_MIN)

`define IGC_TEMP_HI     8'sd35
`define IGC_TEMP_LO     8'sd5
`define IGC_RPM_MIN     12'd430
`define IGC_DISC_CHECK  4'd1
`define IGC_DISC_NORM   4'd3
`define IGC_DSCH_LOG    4'd12
`define IGC_FAULT_CODE  8'h67

`define IGC_REG_CTRL    4'h0
`define IGC_REG_STATUS  4'h4
`define IGC_REG_COUNT   4'h8
`define IGC_REG_SAVED   4'hc
`define IGC_CTRL_CHECK  0
`define IGC_CTRL_CLEAR  1

`endif

//--- rtl/igc_pkg.sv
// Types shared by the generator controller files.
// Assumes nothing of its surroundings.
package igc_pkg;

  typedef enum logic [2:0] {
    IGC_FAN_AUTO,
    IGC_FAN_LO,
    IGC_FAN_LOMED,
    IGC_FAN_MED,
    IGC_FAN_MEDHI,
    IGC_FAN_HI
  } igc_fan_t;

  typedef enum logic [1:0] {
    IGC_STOPPED,
    IGC_MODE_ONLY,
    IGC_COMBINED,
    IGC_SOLO
  } igc_state_t;

endpackage

//--- rtl/igc_tick.sv
// Prescaler giving the shared 100 ms control tick.
// Assumes one free-running system clock.
`timescale 1ns/10ps
module igc_tick #(
  parameter int CYCLES = 5000000
) (
  input  wire logic clock,
  input  wire logic rst_n,
  output logic      tick
);

  logic [31:0] count;

  // -----------------------------------------------------------------
  // Divider
  // -----------------------------------------------------------------
  // shared tick divider
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= 32'h0;
      tick  <= 1'b0;
    end
    else if (count == 32'(CYCLES - 1))
    begin
      count <= 32'h0;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end

endmodule // igc_tick

//--- rtl/igc_ctrl.sv
// Ion generator controller of the indoor unit: operation states, fan and
// vane selection, pausing, timers, power resume and fault detection.
// Assumes all strobes except the abnormal pin come from logic on clock.
`timescale 1ns/10ps
`include "igc_map.svh"
module igc_ctrl
  import igc_pkg::*;
#(
  parameter int TICK_CYCLES = `IGC_TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        power_press,
  input  wire logic        ion_press,
  input  wire logic        off_timer_fire,
  input  wire logic        on_timer_fire,
  input  wire logic        power_resume,
  input  wire logic        nv_saved_run,
  input  wire logic        nv_saved_ion,
  input  wire logic        fan_running,
  input  wire logic [11:0] fan_rpm,
  input  wire logic [7:0]  intake_temp,
  input  wire igc_fan_t    user_fan,
  input  wire logic [3:0]  user_swing,
  input  wire igc_fan_t    mode_fan,
  input  wire logic [3:0]  mode_vane,
  input  wire logic        abnormal_in,
  output logic             unit_run,
  output logic             ion_power,
  output logic             ion_led,
  output logic             timer_led_blink,
  output logic             fault_store,
  output logic [7:0]       ion_generator_fault_code,
  output logic             hidden_log,
  output igc_fan_t         fan_cmd,
  output logic [3:0]       vane_cmd,
  output logic             boost_quiet_en
);

  // Saturating four-bit increment for the fault counters.
  function automatic logic [3:0] inc4(input logic [3:0] v);
    inc4 = (v == 4'hf) ? v : v + 4'h1;
  endfunction

  // Saturating sixteen-bit increment for tick counters.
  function automatic logic [15:0] inc16(input logic [15:0] v);
    inc16 = (v == 16'hffff) ? v : v + 16'h1;
  endfunction

  igc_state_t  state;
  igc_state_t  next_state;
  logic        tick;
  logic        abn_s1;
  logic        abn_s2;
  logic        abn_s3;
  logic        abn;
  logic        check_mode;
  logic        last_run;
  logic        last_ion;
  logic        next_last_run;
  logic        next_last_ion;
  logic        temp_hold;
  logic [15:0] temp_ok_cnt;
  logic [15:0] age;
  logic [15:0] abn_run;
  logic [15:0] normal_run;
  logic [15:0] off_left;
  logic [3:0]  disc_cnt;
  logic [3:0]  dsch_cnt;
  logic        disc_fault;
  logic        logged;

  // -----------------------------------------------------------------
  // Tick and pin synchroniser
  // -----------------------------------------------------------------
  igc_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (tick)
  );

  // Abnormal pin passes three flops; a change counts when two agree.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      abn_s1 <= 1'b0;
      abn_s2 <= 1'b0;
      abn_s3 <= 1'b0;
      abn    <= 1'b0;
    end
    else
    begin
      abn_s1 <= abnormal_in;
      abn_s2 <= abn_s1;
      abn_s3 <= abn_s2;
      if (abn_s2 == abn_s3)
        abn <= abn_s3;
    end
  end

  // -----------------------------------------------------------------
  // Register decode
  // -----------------------------------------------------------------
  wire wr_ctrl   = reg_wr && (reg_addr == `IGC_REG_CTRL);
  wire sw_clear  = wr_ctrl && reg_wdata[`IGC_CTRL_CLEAR];
  wire run_ion   = (state == IGC_COMBINED) || (state == IGC_SOLO);
  wire going_off = (state != IGC_STOPPED) && (next_state == IGC_STOPPED);
  wire temp_out  = ($signed(intake_temp) >= `IGC_TEMP_HI) ||
                   ($signed(intake_temp) <= `IGC_TEMP_LO);

  logic [31:0] rd_value;
  always_comb
  begin
    if (reg_addr == `IGC_REG_CTRL)
      rd_value = {31'h0, check_mode};
    else if (reg_addr == `IGC_REG_STATUS)
      rd_value = {24'h0, logged, disc_fault, temp_hold, ion_power, 2'b00, state};
    else if (reg_addr == `IGC_REG_COUNT)
      rd_value = {20'h0, dsch_cnt, 4'h0, disc_cnt};
    else if (reg_addr == `IGC_REG_SAVED)
      rd_value = {30'h0, last_ion, last_run};
    else
      rd_value = 32'h0;
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rd_value : 32'h0;
  end

  // Check mode bit written by software.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      check_mode <= 1'b0;
    else if (wr_ctrl)
      check_mode <= reg_wdata[`IGC_CTRL_CHECK];
  end

  // -----------------------------------------------------------------
  // Operation state
  // -----------------------------------------------------------------
  // Power stop beats the off timer, which beats the generator button except in standalone, where the button wins.
  always_comb
  begin
    next_state    = state;
    next_last_run = last_run;
    next_last_ion = last_ion;
    case (state)
      IGC_STOPPED:
      begin
        if (power_resume)
        begin
          if (nv_saved_run)
            next_state = nv_saved_ion ? IGC_COMBINED : IGC_MODE_ONLY;
          else if (nv_saved_ion)
            next_state = IGC_SOLO;
        end
        else if (power_press)
          next_state = IGC_MODE_ONLY;
        else if (on_timer_fire)
        begin
          if (last_run)
            next_state = last_ion ? IGC_COMBINED : IGC_MODE_ONLY;
          else if (last_ion)
            next_state = IGC_SOLO;
          else
            next_state = IGC_MODE_ONLY;
        end
        else if (ion_press)
          next_state = IGC_SOLO;
      end
      IGC_MODE_ONLY:
      begin
        if (power_press)
          next_state = IGC_STOPPED;
        else if (off_timer_fire)
        begin
          next_state    = IGC_STOPPED;
          next_last_run = 1'b1;
          next_last_ion = 1'b0;
        end
        else if (ion_press)
          next_state = IGC_COMBINED;
      end
      IGC_COMBINED:
      begin
        if (power_press)
          next_state = IGC_STOPPED;
        else if (off_timer_fire)
        begin
          next_state    = IGC_STOPPED;
          next_last_run = 1'b1;
          next_last_ion = 1'b1;
        end
        else if (ion_press)
          next_state = IGC_MODE_ONLY;
      end
      default:
      begin
        if (power_press || ion_press)
          next_state = IGC_STOPPED;
        else if (off_timer_fire)
        begin
          next_state    = IGC_STOPPED;
          next_last_run = 1'b0;
          next_last_ion = 1'b1;
        end
      end
    endcase
  end

  // State and saved status registers.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= IGC_STOPPED;
      last_run <= 1'b0;
      last_ion <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      last_run <= next_last_run;
      last_ion <= next_last_ion;
    end
  end

  // -----------------------------------------------------------------
  // Pause conditions and generator supply
  // -----------------------------------------------------------------
  // six in-band minutes before the hold lifts
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      temp_hold   <= 1'b0;
      temp_ok_cnt <= 16'h0;
    end
    else if (temp_out)
    begin
      temp_hold   <= 1'b1;
      temp_ok_cnt <= 16'h0;
    end
    else if (tick && temp_hold)
    begin
      temp_ok_cnt <= inc16(temp_ok_cnt);
      if (inc16(temp_ok_cnt) >= `IGC_TEMP_OK)
        temp_hold <= 1'b0;
    end
  end

  // fan stop pause, fan speed gate
  wire paused = !fan_running || temp_hold ||
                ((state == IGC_COMBINED) && (fan_rpm < `IGC_RPM_MIN));
  wire next_ion_power = run_ion && !paused && (off_left == 16'h0) && !disc_fault;

  // -----------------------------------------------------------------
  // Fault detection
  // -----------------------------------------------------------------
  // disconnection inside the early window
  wire disc_evt = tick && abn && ion_power &&
                  (age >= `IGC_DISC_START) && (age < `IGC_DISC_END) &&
                  (inc16(abn_run) >= `IGC_DISC_ABN);
  // discharge fault after thirty powered minutes
  wire dsch_evt = tick && abn && ion_power && (age >= `IGC_DSCH_START) &&
                  (inc16(abn_run) >= `IGC_DSCH_ABN);
  wire disc_judge = check_mode ? (disc_cnt >= `IGC_DISC_CHECK)
                               : (disc_cnt >= `IGC_DISC_NORM);

  // Powered age and continuous abnormal time, both in ticks.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      age     <= 16'h0;
      abn_run <= 16'h0;
    end
    else if (!ion_power || !abn || disc_evt || dsch_evt)
    begin
      age     <= ion_power ? (tick ? inc16(age) : age) : 16'h0;
      abn_run <= 16'h0;
    end
    else if (tick)
    begin
      age <= inc16(age);
      // Each window starts its own continuous run.
      if ((age == `IGC_DISC_START - 16'h1) || (age == `IGC_DSCH_START - 16'h1))
        abn_run <= 16'h0;
      else if (age >= `IGC_DISC_START)
        abn_run <= inc16(abn_run);
    end
  end

  // five minutes off, thirty minutes off
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      off_left <= 16'h0;
    else if (disc_evt)
      off_left <= `IGC_DISC_OFF;
    else if (dsch_evt)
      off_left <= `IGC_DSCH_OFF;
    else if (tick && (off_left != 16'h0))
      off_left <= off_left - 16'h1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      normal_run <= 16'h0;
    else if (!ion_power || abn)
      normal_run <= 16'h0;
    else if (tick)
      normal_run <= inc16(normal_run);
  end

  // Fault counters; a new event wins over any clear in the same cycle.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      disc_cnt <= 4'h0;
      dsch_cnt <= 4'h0;
    end
    else
    begin
      if (disc_evt)
        disc_cnt <= inc4(disc_cnt);
      else if (sw_clear || (going_off && !check_mode))
        disc_cnt <= 4'h0;
      // count up, clear on stop or long normal run
      if (dsch_evt)
        dsch_cnt <= inc4(dsch_cnt);
      else if (sw_clear || going_off || (normal_run >= `IGC_DSCH_CLR))
        dsch_cnt <= 4'h0;
    end
  end

  // Fault latches and one-cycle store strobes.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      disc_fault  <= 1'b0;
      logged      <= 1'b0;
      fault_store <= 1'b0;
      hidden_log  <= 1'b0;
    end
    else
    begin
      // declare fault, store once
      // A clear wins here: the judgement still reads the count that it clears.
      disc_fault  <= (disc_judge || disc_fault) && !sw_clear;
      fault_store <= disc_judge && !disc_fault;
      logged      <= ((dsch_cnt >= `IGC_DSCH_LOG) || logged) && !sw_clear;
      hidden_log  <= (dsch_cnt >= `IGC_DSCH_LOG) && !logged;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  // standalone fan, mode fan
  wire igc_fan_t solo_fan = (user_fan == IGC_FAN_AUTO) ? IGC_FAN_MED : user_fan;
  wire igc_fan_t next_fan = (state == IGC_SOLO) ? solo_fan : mode_fan;
  wire [3:0] next_vane = (state == IGC_SOLO) ? user_swing : mode_vane;

  // Registered drive to the unit and the generator.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unit_run        <= 1'b0;
      ion_power       <= 1'b0;
      ion_led         <= 1'b0;
      timer_led_blink <= 1'b0;
      fan_cmd         <= IGC_FAN_AUTO;
      vane_cmd        <= 4'h0;
      boost_quiet_en  <= 1'b1;
      ion_generator_fault_code <= 8'h00;
    end
    else
    begin
      unit_run        <= (state == IGC_MODE_ONLY) || (state == IGC_COMBINED);
      ion_power       <= next_ion_power;
      ion_led         <= run_ion && !disc_fault;
      // blink in check mode, no blink outside
      timer_led_blink <= disc_fault && check_mode;
      fan_cmd         <= next_fan;
      vane_cmd        <= next_vane;
      boost_quiet_en  <= (state != IGC_SOLO);
      ion_generator_fault_code <= disc_fault ? `IGC_FAULT_CODE : 8'h00;
    end
  end

endmodule // igc_ctrl

//--- sim/igc_ctrl_sva.sv
// Port checker for the generator controller.
// Assumes it is bound to igc_ctrl and sees only that module's ports.
`timescale 1ns/10ps
module igc_ctrl_sva
  import igc_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        fan_running,
  input wire logic [11:0] fan_rpm,
  input wire logic [7:0]  intake_temp,
  input wire igc_fan_t    user_fan,
  input wire logic [3:0]  user_swing,
  input wire igc_fan_t    mode_fan,
  input wire logic [3:0]  mode_vane,
  input wire logic        unit_run,
  input wire logic        ion_power,
  input wire logic        ion_led,
  input wire logic        fault_store,
  input wire logic [7:0]  ion_generator_fault_code,
  input wire igc_fan_t    fan_cmd,
  input wire logic [3:0]  vane_cmd,
  input wire logic        boost_quiet_en
);
  // Standalone running and out-of-band intake as seen at the ports.
  wire solo = ion_led && !unit_run;
  wire hot  = ($signed(intake_temp) >= 8'sd35) || ($signed(intake_temp) <= 8'sd5);

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside its slot");
  chk_solo_quiet: assert property (solo |-> !boost_quiet_en)
    else $error("boost and quiet left on in standalone");
  chk_solo_fan: assert property (solo && $stable(user_fan) |->
    ((user_fan == IGC_FAN_AUTO) ? fan_cmd == IGC_FAN_MED : fan_cmd == user_fan))
    else $error("standalone fan does not follow the user");
  chk_solo_vane: assert property (solo && $stable(user_swing) |-> vane_cmd == user_swing)
    else $error("standalone vane does not follow the user");
  chk_mode_air: assert property (ion_led && unit_run && $stable(mode_fan)
    && $stable(mode_vane) |-> fan_cmd == mode_fan && vane_cmd == mode_vane)
    else $error("combined airflow not taken from the mode");
  chk_rpm_gate: assert property (unit_run && ion_power && $stable(fan_rpm)
    && fan_rpm == $past(fan_rpm, 2) |-> fan_rpm >= 12'd430)
    else $error("generator powered below the fan speed floor");
  chk_fan_pause: assert property (!fan_running && !$past(fan_running)
    && !$past(fan_running, 2) |-> !ion_power)
    else $error("generator powered with the fan stopped");
  chk_temp_pause: assert property (hot && $past(hot) && $past(hot, 2) |-> !ion_power)
    else $error("generator powered with intake out of band");
  chk_code_set: assert property (fault_store |->
    ##[0:2] (ion_generator_fault_code == 8'h67 && !ion_led))
    else $error("fault store without code or with indicator on");
  chk_latch_dark: assert property ($past(ion_generator_fault_code) == 8'h67
    && ion_generator_fault_code == 8'h67 |-> !ion_led && !ion_power)
    else $error("indicator or supply on while the fault is latched");
  chk_store_pulse: assert property (fault_store |=> !fault_store)
    else $error("fault store longer than one cycle");

  // Main scenarios reached.
  cov_solo: cover property (solo && ion_power);
  cov_comb: cover property (ion_led && unit_run && ion_power);
  cov_store: cover property (fault_store);
endmodule // igc_ctrl_sva

//--- sim/igc_ion_unit.sv
// Behavioural far side: the generator head and the indoor fan.
// Assumes the bench steers the head fault and the fan target.
`timescale 1ns/10ps
module igc_ion_unit (
  input  wire logic        clock,
  input  wire logic        ion_power,
  input  wire logic        broken,
  input  wire logic        fan_on,
  input  wire logic [11:0] rpm_set,
  output logic             abnormal_in,
  output logic             fan_running,
  output logic [11:0]      fan_rpm
);
  initial abnormal_in = 1'b0;

  // A broken head reports abnormal only while it is supplied, a clock late.
  always @(posedge clock)
  begin
    abnormal_in <= broken & ion_power;
  end

  // A stopped fan reports no speed at all.
  assign fan_running = fan_on;
  assign fan_rpm     = fan_on ? rpm_set : 12'h000;
endmodule // igc_ion_unit

//--- sim/test_ion_generator_control.sv
// Self-checking bench for the generator controller.
// Assumes a 50 MHz clock and a simulation tick of 10 clock cycles.
`timescale 1ns/10ps
module test_ion_generator_control;
  import igc_pkg::*;
  localparam int PWR = 0, ION = 1, OFFT = 2, ONT = 3, RES = 4;
  logic        clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0, user_swing = 4'h9, mode_vane = 4'h3, vane_cmd;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
  logic [4:0]  ev = 5'h00;
  logic        nv_saved_run = 1'b0, nv_saved_ion = 1'b0, broken = 1'b0, fan_on = 1'b1;
  logic [11:0] rpm_set = 12'd500, fan_rpm;
  logic [7:0]  intake_temp = 8'h19, ion_generator_fault_code;
  igc_fan_t    user_fan = IGC_FAN_AUTO, mode_fan = IGC_FAN_HI, fan_cmd;
  logic        fan_running, abnormal_in, unit_run, ion_power, ion_led, timer_led_blink;
  logic        fault_store, hidden_log, boost_quiet_en;
  int          failures = 0, n_compared = 0, cycles = 0, stores = 0, n, s0;

  always #10 clock = ~clock;

  igc_ctrl #(.TICK_CYCLES(10)) i_dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .power_press(ev[PWR]), .ion_press(ev[ION]),
    .off_timer_fire(ev[OFFT]), .on_timer_fire(ev[ONT]), .power_resume(ev[RES]),
    .nv_saved_run, .nv_saved_ion, .fan_running, .fan_rpm, .intake_temp, .user_fan,
    .user_swing, .mode_fan, .mode_vane, .abnormal_in, .unit_run, .ion_power, .ion_led,
    .timer_led_blink, .fault_store, .ion_generator_fault_code, .hidden_log, .fan_cmd,
    .vane_cmd, .boost_quiet_en);
  igc_ion_unit i_unit (.clock, .ion_power, .broken, .fan_on, .rpm_set, .abnormal_in,
    .fan_running, .fan_rpm);

  // Cycle ceiling and tally of fault store pulses.
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (fault_store === 1'b1) stores <= stores + 1;
    if (cycles == 60000)
    begin
      failures = failures + 1;
      conclude();
    end
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen); end
  endtask
  task conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task settle(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  // One-cycle event pulse, then wait until its outputs stand.
  task press(input int b);
    @(posedge clock); ev[b] <= 1'b1;
    @(posedge clock); ev[b] <= 1'b0;
    settle(2);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clock); reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clock); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clock); reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task outs(input logic run, input logic led, input logic pwr);
    check("unit_run", unit_run, run);
    check("ion_led", ion_led, led);
    check("ion_power", ion_power, pwr);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_idle();
    outs(0, 0, 0);
    check("boost", boost_quiet_en, 1);
    check("hidden", hidden_log, 0); // no log without faults
    rd(4'h8); check("count", rd_val, 0);
    wr(4'h2, 32'hffffffff); rd(4'h2); check("unmapped", rd_val, 0);
  endtask
  task t_solo();
    press(ION); outs(0, 1, 1); // standalone start
    check("boost", boost_quiet_en, 0); // boost disabled
    check("fan", fan_cmd, IGC_FAN_MED); // auto maps medium
    check("vane", vane_cmd, 4'h9); // user swing
    @(posedge clock); user_fan <= IGC_FAN_LO;
    settle(2); check("fan", fan_cmd, IGC_FAN_LO); // user speed
    rd(4'h4); check("status", rd_val[4:0], 5'h13); // standalone state
    press(ION); outs(0, 0, 0); // second press stops
  endtask
  task t_resume();
    @(posedge clock); nv_saved_ion <= 1'b1;
    press(RES); outs(0, 1, 1); // standalone back
    press(ION);
    @(posedge clock); nv_saved_run <= 1'b1;
    press(RES); outs(1, 1, 1); // combined back
    press(PWR); outs(0, 0, 0); // power stops
  endtask
  task t_check();
    wr(4'h0, 32'h1);
    @(posedge clock); broken <= 1'b1;
    press(ION); n = 0;
    while (fault_store !== 1'b1 && n < 1000) begin settle(1); n++; end
    check("detect time", n >= 660 && n <= 720, 1); // detection window
    settle(3);
    check("code", ion_generator_fault_code, 8'h67); // code declared
    check("blink", timer_led_blink, 1); // timer blinks
    outs(0, 0, 0); // indicator off
    rd(4'h8); check("count", rd_val[3:0], 1); // counted once
    @(posedge clock); broken <= 1'b0;
    wr(4'h0, 32'h2); settle(2);
    check("code", ion_generator_fault_code, 0);
    check("blink", timer_led_blink, 0);
    press(ION); outs(0, 0, 0); // press stops
  endtask
  task t_normal();
    @(posedge clock); broken <= 1'b1; s0 = stores;
    press(ION); n = 0;
    while (ion_power !== 1'b0 && n < 1000) begin settle(1); n++; end
    check("stores", stores, s0); // no store below three
    check("ion_led", ion_led, 1); // indicator kept
    check("blink", timer_led_blink, 0); // no blink
    rd(4'h8); check("count", rd_val[3:0], 1); // counter up
    @(posedge clock); broken <= 1'b0; n = 0;
    while (ion_power !== 1'b1 && n < 31000) begin settle(1); n++; end
    check("off time", n >= 29970 && n <= 30020, 1); // five minute rest
    press(ION); rd(4'h8); check("count", rd_val[3:0], 0); // cleared on stop
  endtask
  task t_comb();
    press(PWR); outs(1, 0, 0);
    press(ION); outs(1, 1, 1); // combined start
    check("fan", fan_cmd, IGC_FAN_HI); // mode fan
    check("vane", vane_cmd, 4'h3); // mode vane
    @(posedge clock); rpm_set <= 12'd429;
    settle(4); check("ion_power", ion_power, 0); // below floor
    @(posedge clock); rpm_set <= 12'd430;
    settle(4); check("ion_power", ion_power, 1); // at floor
    @(posedge clock); fan_on <= 1'b0;
    settle(4); check("ion_power", ion_power, 0); // fan stopped
    @(posedge clock); fan_on <= 1'b1;
    settle(4); check("ion_power", ion_power, 1); // fan restarted
    @(posedge clock); intake_temp <= 8'h23;
    settle(4); check("ion_power", ion_power, 0); // hot intake
    @(posedge clock); intake_temp <= 8'h19;
    settle(4); check("ion_power", ion_power, 0); // still held after return to band
    press(OFFT); outs(0, 0, 0); // all stops
    rd(4'hc); check("saved", rd_val[1:0], 2'b11); // status saved
    press(ONT); check("run", unit_run, 1); check("led", ion_led, 1); // restored
    press(ONT); check("run", unit_run, 1); check("led", ion_led, 1); // no change
    press(PWR); outs(0, 0, 0); // power stops
  endtask

  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    settle(1);
    t_idle();
    t_solo();
    t_resume();
    t_check();
    // Reset in mid-run also ends the rest time that the check scenario left.
    rst_n <= 1'b0;
    settle(3);
    rst_n <= 1'b1;
    settle(1);
    outs(0, 0, 0);
    rd(4'h8); check("count", rd_val, 0); // counters cleared by reset
    t_normal();
    t_comb();
    conclude();
  end
endmodule // test_ion_generator_control

bind igc_ctrl igc_ctrl_sva i_sva (.clock, .rst_n, .reg_rd, .reg_rdata, .fan_running,
  .fan_rpm, .intake_temp, .user_fan, .user_swing, .mode_fan, .mode_vane, .unit_run,
  .ion_power, .ion_led, .fault_store, .ion_generator_fault_code, .fan_cmd, .vane_cmd,
  .boost_quiet_en);
